// ### core/pfd_defines.svh
`ifndef PFD_DEFINES_SVH
`define PFD_DEFINES_SVH

// ----------------------------------------------------------------
// five-unit character codes, impulse 1 in bit 0
// ----------------------------------------------------------------
`define PFD_CODE_BLANK   5'h00
`define PFD_CODE_SPACE   5'h04
`define PFD_CODE_SIGNAL  5'h05
`define PFD_CODE_LF      5'h02
`define PFD_CODE_CR      5'h08
`define PFD_CODE_LTRS    5'h1f
`define PFD_CODE_FIGS    5'h1b

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PFD_OFS_CTRL     8'h00
`define PFD_OFS_STATUS   8'h04
`define PFD_OFS_LINE_LEN 8'h08
`define PFD_OFS_COLUMN   8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PFD_CTRL_UNSHIFT_EN  0
`define PFD_CTRL_UNLOCK      1
`define PFD_STAT_FIGS        0
`define PFD_STAT_BLANK       1
`define PFD_STAT_LOCK        2
`define PFD_STAT_AUTO_EOL    3

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define PFD_COL_W            7
`define PFD_LINE_LEN_RST     7'h48
`define PFD_UNSHIFT_EN_RST   1'b1

`endif

// ### core/pfd_pkg.sv
`include "pfd_defines.svh"

package pfd_pkg;

    // ----------------------------------------------------------------
    // shift state of the type basket
    // ----------------------------------------------------------------
    typedef enum logic {
        PFD_LETTERS,
        PFD_FIGURES
    } pfd_shift_t;

    // codes that work a function and never print
    function automatic logic pfd_is_function(input logic [4:0] code, input pfd_shift_t shift);
        logic fn;
        fn = (code == `PFD_CODE_BLANK) || (code == `PFD_CODE_SPACE) ||
             (code == `PFD_CODE_LF) || (code == `PFD_CODE_CR) ||
             (code == `PFD_CODE_LTRS) || (code == `PFD_CODE_FIGS) ||
             ((code == `PFD_CODE_SIGNAL) && (shift == PFD_FIGURES));
        return fn;
    endfunction : pfd_is_function

endpackage : pfd_pkg

// ### core/pfd_blank_lock.sv
`timescale 1ns/1ns
`include "pfd_defines.svh"

module pfd_blank_lock (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // decoded character
    input  wire logic char_take,    // one character this cycle
    input  wire logic char_blank,   // the character is blank
    // software release
    input  wire logic unlock_req,
    // state
    output logic      blank_latch,
    output logic      lock
);

    logic latch_reg;   // first blank seen
    logic latch_next;
    logic lock_reg;    // keyboard locked
    logic lock_next;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        latch_next = latch_reg;
        lock_next  = lock_reg;
        if (char_take) begin
            // lock is decided from the old latch, before it clears
            if (char_blank && latch_reg) begin
                lock_next = 1'b1;
            end
            // first blank only latches; any other code clears
            latch_next = char_blank && !latch_reg;
        end
        // release loses against a lock in the same cycle
        if (unlock_req && !(char_take && char_blank && latch_reg)) begin
            lock_next = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_reg <= 1'b0;
            lock_reg  <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            lock_reg  <= lock_next;
        end
    end

    assign blank_latch = latch_reg;
    assign lock        = lock_reg;

endmodule : pfd_blank_lock

// ### core/pfd_column.sv
`timescale 1ns/1ns
`include "pfd_defines.svh"

module pfd_column (
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // carriage motion
    input  wire logic                   advance,    // print or space
    input  wire logic                   ret,        // carriage return
    input  wire logic [`PFD_COL_W-1:0]  line_len,
    // position
    output logic      [`PFD_COL_W-1:0]  column,
    output logic                        near_end    // one character before the margin
);

    logic [`PFD_COL_W-1:0] col_reg;
    logic [`PFD_COL_W-1:0] col_next;
    logic [`PFD_COL_W-1:0] last_col;

    // ----------------------------------------------------------------
    // next position; the carriage stops at the last column
    // ----------------------------------------------------------------
    always_comb begin
        last_col = line_len - `PFD_COL_W'(1);
        col_next = col_reg;
        if (ret) begin
            col_next = '0;
        end else if (advance && (col_reg < last_col)) begin
            col_next = col_reg + `PFD_COL_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            col_reg <= '0;
        end else begin
            col_reg <= col_next;
        end
    end

    assign column   = col_reg;
    assign near_end = (col_reg == last_col);

endmodule : pfd_column

// ### core/pfd_printer_function_decoder.sv
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`include "pfd_defines.svh"

module pfd_printer_function_decoder
    import pfd_pkg::*;
(
    // ahb-lite clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // character selector
    input  wire logic [4:0]  char_code,
    input  wire logic        char_valid,
    // carriage end-of-line contact
    input  wire logic        eol_pin,
    // printer actions
    output logic             cr_pulse,
    output logic             lf_pulse,
    output logic             bell_pulse,
    output logic             print_pulse,
    output logic             space_pulse,
    output logic             kbd_lock,
    output logic             shift_figs
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    // bus pipeline
    logic                  wr_pend_reg;      // write data phase due
    logic                  wr_pend_next;
    logic [7:0]            wr_addr_reg;      // byte offset of pending write
    logic [7:0]            wr_addr_next;
    logic [31:0]           rdata_reg;        // read data for next data phase
    logic [31:0]           rdata_next;
    logic                  addr_take;        // valid address phase
    // software state
    logic                  unshift_en_reg;   // unshift on space enabled
    logic                  unshift_en_next;
    logic [`PFD_COL_W-1:0] line_len_reg;     // characters per line
    logic [`PFD_COL_W-1:0] line_len_next;
    logic                  auto_seen_reg;    // sticky: an auto end-of-line fired
    logic                  auto_seen_next;
    logic                  unlock_req;       // write-one strobe to release lock
    // pin synchroniser
    logic                  eol_s1_reg;       // first stage, read only by second
    logic                  eol_s2_reg;
    logic                  eol_s3_reg;       // delayed copy for edge detect
    // decode state
    pfd_shift_t            shift_reg;
    pfd_shift_t            shift_next;
    logic                  near_end_d_reg;   // previous near-end level
    // action outputs
    logic                  cr_reg;
    logic                  cr_next;
    logic                  lf_reg;
    logic                  lf_next;
    logic                  bell_reg;
    logic                  bell_next;
    logic                  print_reg;
    logic                  print_next;
    logic                  space_reg;
    logic                  space_next;
    // decoded character
    logic                  is_blank;
    logic                  is_space;
    logic                  is_cr;
    logic                  is_lf;
    logic                  is_printing;
    logic                  auto_fire;
    // submodule outputs
    logic                  blank_latch;
    logic                  lock_w;
    logic [`PFD_COL_W-1:0] column;
    logic                  near_end;

    // ----------------------------------------------------------------
    // character decode
    // ----------------------------------------------------------------
    // the selector strobes each code for exactly one cycle
    always_comb begin
        is_blank    = char_valid && (char_code == `PFD_CODE_BLANK);
        is_space    = char_valid && (char_code == `PFD_CODE_SPACE);
        is_cr       = char_valid && (char_code == `PFD_CODE_CR);
        is_lf       = char_valid && (char_code == `PFD_CODE_LF);
        // functions never print, the space code among them
        is_printing = char_valid && !pfd_is_function(char_code, shift_reg);
    end

    // ----------------------------------------------------------------
    // automatic end-of-line
    // ----------------------------------------------------------------
    // fires on the carriage reaching one before the margin, either from the
    // column count or from the contact; a return or feed already arriving
    // this cycle makes it unnecessary
    // no received code starts the trigger; return and feed codes only block it
    always_comb begin
        auto_fire = ((near_end && !near_end_d_reg) || (eol_s2_reg && !eol_s3_reg)) &&
                    !is_cr && !is_lf;
    end

    // ----------------------------------------------------------------
    // action and shift next state
    // ----------------------------------------------------------------
    always_comb begin
        shift_next = shift_reg;
        if (char_valid) begin
            if (char_code == `PFD_CODE_LTRS) begin
                shift_next = PFD_LETTERS;
            end else if (char_code == `PFD_CODE_FIGS) begin
                shift_next = PFD_FIGURES;
            end else if (is_space && unshift_en_reg) begin
                // unshift only when the configuration bit allows it
                shift_next = PFD_LETTERS;
            end
        end
        // auto request drives both actions in the same cycle
        cr_next    = is_cr || auto_fire;
        lf_next    = is_lf || auto_fire;
        // seven-condition match: valid, five code bits and figures shift
        bell_next  = char_valid && (char_code == `PFD_CODE_SIGNAL) && (shift_reg == PFD_FIGURES);
        print_next = is_printing;
        // unshift does not suppress the spacing advance
        space_next = is_space;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg      <= PFD_LETTERS;
            cr_reg         <= 1'b0;
            lf_reg         <= 1'b0;
            bell_reg       <= 1'b0;
            print_reg      <= 1'b0;
            space_reg      <= 1'b0;
            near_end_d_reg <= 1'b0;
        end else begin
            shift_reg      <= shift_next;
            cr_reg         <= cr_next;
            lf_reg         <= lf_next;
            bell_reg       <= bell_next;
            print_reg      <= print_next;
            space_reg      <= space_next;
            near_end_d_reg <= near_end;
        end
    end

    // ----------------------------------------------------------------
    // end-of-line contact synchroniser
    // ----------------------------------------------------------------
    // the contact is mechanical and asynchronous, so two stages first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eol_s1_reg <= 1'b0;
            eol_s2_reg <= 1'b0;
            eol_s3_reg <= 1'b0;
        end else begin
            eol_s1_reg <= eol_pin;
            eol_s2_reg <= eol_s1_reg;
            eol_s3_reg <= eol_s2_reg;
        end
    end

    // ----------------------------------------------------------------
    // blank latch and keyboard lock
    // ----------------------------------------------------------------
    pfd_blank_lock u_blank_lock (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .char_take   (char_valid),
        .char_blank  (is_blank),
        .unlock_req  (unlock_req),
        .blank_latch (blank_latch),
        .lock        (lock_w)
    );

    // ----------------------------------------------------------------
    // carriage position
    // ----------------------------------------------------------------
    // printing characters and spaces move the carriage; a return homes it
    pfd_column u_column (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .advance  (is_printing || is_space),
        .ret      (is_cr || auto_fire),
        .line_len (line_len_reg),
        .column   (column),
        .near_end (near_end)
    );

    // ----------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------------------------------
    // read data is fetched in the address phase so hrdata leaves a flop;
    // a read directly after a write to the same word would see the old
    // value, which the single-transfer master never produces
    always_comb begin
        addr_take       = hsel && hready && htrans[1];
        wr_pend_next    = addr_take && hwrite;
        wr_addr_next    = addr_take ? haddr[7:0] : wr_addr_reg;
        rdata_next      = '0;
        unshift_en_next = unshift_en_reg;
        line_len_next   = line_len_reg;
        auto_seen_next  = auto_seen_reg;
        unlock_req      = 1'b0;
        // read mux; unmapped words read zero
        if (addr_take && !hwrite) begin
            case (haddr[7:0])
                `PFD_OFS_CTRL: begin
                    rdata_next[`PFD_CTRL_UNSHIFT_EN] = unshift_en_reg;
                end
                `PFD_OFS_STATUS: begin
                    rdata_next[`PFD_STAT_FIGS]     = (shift_reg == PFD_FIGURES);
                    rdata_next[`PFD_STAT_BLANK]    = blank_latch;
                    rdata_next[`PFD_STAT_LOCK]     = lock_w;
                    rdata_next[`PFD_STAT_AUTO_EOL] = auto_seen_reg;
                end
                `PFD_OFS_LINE_LEN: begin
                    rdata_next[`PFD_COL_W-1:0] = line_len_reg;
                end
                `PFD_OFS_COLUMN: begin
                    rdata_next[`PFD_COL_W-1:0] = column;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
        // write data phase
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `PFD_OFS_CTRL: begin
                    unshift_en_next = hwdata[`PFD_CTRL_UNSHIFT_EN];
                    unlock_req      = hwdata[`PFD_CTRL_UNLOCK];
                end
                `PFD_OFS_STATUS: begin
                    // write one to clear the sticky flag
                    if (hwdata[`PFD_STAT_AUTO_EOL]) begin
                        auto_seen_next = 1'b0;
                    end
                end
                `PFD_OFS_LINE_LEN: begin
                    line_len_next = hwdata[`PFD_COL_W-1:0];
                end
                default: begin
                    unlock_req = 1'b0;   // read-only or unmapped: ignored
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        if (auto_fire) begin
            auto_seen_next = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg    <= 1'b0;
            wr_addr_reg    <= '0;
            rdata_reg      <= '0;
            unshift_en_reg <= `PFD_UNSHIFT_EN_RST;
            line_len_reg   <= `PFD_LINE_LEN_RST;
            auto_seen_reg  <= 1'b0;
        end else begin
            wr_pend_reg    <= wr_pend_next;
            wr_addr_reg    <= wr_addr_next;
            rdata_reg      <= rdata_next;
            unshift_en_reg <= unshift_en_next;
            line_len_reg   <= line_len_next;
            auto_seen_reg  <= auto_seen_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs, each straight from a flop except the tied hreadyout and hresp
    // ----------------------------------------------------------------
    assign hrdata      = rdata_reg;
    assign hreadyout   = 1'b1;           // never stalls
    assign hresp       = 1'b0;           // always okay
    assign cr_pulse    = cr_reg;
    assign lf_pulse    = lf_reg;
    assign bell_pulse  = bell_reg;
    assign print_pulse = print_reg;
    assign space_pulse = space_reg;
    assign kbd_lock    = lock_w;
    assign shift_figs  = (shift_reg == PFD_FIGURES);

endmodule : pfd_printer_function_decoder

// ### verification/pfd_printer_function_decoder_checker.sv
`timescale 1ns/1ns
`include "pfd_defines.svh"

// ----------------------------------------------------------------
// port checks of the function decoder
// ----------------------------------------------------------------
module pfd_decoder_checker (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // character selector
    input wire logic [4:0] char_code,
    input wire logic       char_valid,
    // printer actions
    input wire logic       cr_pulse,
    input wire logic       lf_pulse,
    input wire logic       bell_pulse,
    input wire logic       print_pulse,
    input wire logic       space_pulse,
    input wire logic       kbd_lock,
    input wire logic       shift_figs
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // strobed codes, each qualified by the valid strobe
    wire logic sig_c   = char_valid && (char_code == `PFD_CODE_SIGNAL);
    wire logic blank_c = char_valid && (char_code == `PFD_CODE_BLANK);
    wire logic space_c = char_valid && (char_code == `PFD_CODE_SPACE);
    wire logic bell_c  = sig_c && shift_figs;   // shift before the edge decides

    // an uncaused pair can only come from the end-of-line path
    AST_AUTO_PAIR: assert property ((cr_pulse || lf_pulse) && !$past(char_valid) |-> cr_pulse && lf_pulse)
        else $error("return and feed split without a code");
    // a lone return or feed must trace back to its own code
    AST_AUTO_NOCODE: assert property ((cr_pulse != lf_pulse) |-> $past(char_valid) &&
        ($past(char_code) == (cr_pulse ? `PFD_CODE_CR : `PFD_CODE_LF)))
        else $error("single return or feed with no matching code");
    AST_BELL_FIGS: assert property (bell_c |=> bell_pulse)
        else $error("signal code in figures gave no bell");
    AST_BELL_LTRS: assert property (sig_c && !shift_figs |=> !bell_pulse)
        else $error("bell rang in letters shift");
    // every bell pulse follows a signal code taken in figures shift the cycle before
    AST_BELL_CAUSE: assert property (bell_pulse |-> $past(bell_c))
        else $error("bell without signal code in figures");
    AST_FN_NOPRINT: assert property (blank_c || space_c |=> !print_pulse)
        else $error("function code printed");
    AST_SPACE_ADV: assert property (space_c |=> space_pulse)
        else $error("space code gave no spacing");
    AST_LOCK_CAUSE: assert property ($rose(kbd_lock) |-> $past(blank_c))
        else $error("keyboard locked without a blank code");
    // reset holds the outputs quiet, so this one runs during reset
    AST_RESET: assert property (disable iff (1'b0) !hresetn |-> !kbd_lock && !shift_figs &&
        !cr_pulse && !lf_pulse && !bell_pulse)
        else $error("output active during reset");

    // main scenarios reached
    COV_BELL: cover property (bell_pulse);
    COV_LOCK: cover property ($rose(kbd_lock));
    COV_AUTO: cover property (cr_pulse && lf_pulse && !$past(char_valid));
    COV_SPACE: cover property (space_pulse && !shift_figs);
endmodule : pfd_decoder_checker

bind pfd_printer_function_decoder pfd_decoder_checker chk_i (.hclk, .hresetn, .char_code, .char_valid,
    .cr_pulse, .lf_pulse, .bell_pulse, .print_pulse, .space_pulse, .kbd_lock, .shift_figs);

// ### verification/pfd_selector_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// character selector and carriage end-of-line contact
// ----------------------------------------------------------------
module pfd_selector_model (
    // clock
    input  wire logic       hclk,
    // selector outputs
    output logic      [4:0] char_code,
    output logic            char_valid,
    output logic            eol_pin
);
    // idle at time zero
    initial begin
        char_code  = 5'h00;
        char_valid = 1'b0;
        eol_pin    = 1'b0;
    end

    // one code per cycle, back to back, valid held across the run
    task automatic send(input logic [4:0] cs[$]);
        foreach (cs[i]) begin
            char_code  <= cs[i];
            char_valid <= 1'b1;
            @(posedge hclk);
        end
        char_valid <= 1'b0;
        // idle lines show the inverse, so a stale code is never read
        char_code  <= ~cs[cs.size()-1];
    endtask : send

    // contact closes for a while, as the ring passes it
    task automatic eol_hit();
        eol_pin <= 1'b1;
        repeat (6) @(posedge hclk);
        eol_pin <= 1'b0;
    endtask : eol_hit
endmodule : pfd_selector_model

// ### verification/pfd_printer_function_decoder_tb_top.sv
`timescale 1ns/1ns
`include "pfd_defines.svh"

// ----------------------------------------------------------------
// function decoder testbench
// ----------------------------------------------------------------
module pfd_printer_function_decoder_tb_top;
    // bus master side
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b1;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] rd;
    // design outputs
    wire logic [31:0] hrdata;
    wire logic        hreadyout, hresp, cr_pulse, lf_pulse, bell_pulse;
    wire logic        print_pulse, space_pulse, kbd_lock, shift_figs;
    wire logic [4:0]  char_code;
    wire logic        char_valid, eol_pin;
    // bookkeeping and pulse counts
    int miscompares = 0;
    int tests_run   = 0;
    int n_cr = 0, n_lf = 0, n_bell = 0, n_prt = 0, n_spc = 0;
    // reset table: ctrl, status, line length, column, unmapped
    localparam logic [7:0]  RA [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    localparam logic [31:0] RV [5] = '{32'h1, 32'h0, 32'h48, 32'h0, 32'h0};

    pfd_printer_function_decoder uut (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .char_code, .char_valid, .eol_pin,
        .cr_pulse, .lf_pulse, .bell_pulse, .print_pulse, .space_pulse, .kbd_lock, .shift_figs
    );
    pfd_selector_model sel (.hclk, .char_code, .char_valid, .eol_pin);

    // 125 MHz clock
    initial begin
        forever #4 hclk = ~hclk;
    end

    // count each one-cycle action pulse
    always @(posedge hclk) begin
        n_cr   <= n_cr + (cr_pulse === 1'b1);
        n_lf   <= n_lf + (lf_pulse === 1'b1);
        n_bell <= n_bell + (bell_pulse === 1'b1);
        n_prt  <= n_prt + (print_pulse === 1'b1);
        n_spc  <= n_spc + (space_pulse === 1'b1);
    end

    task automatic conclude();
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // single ahb-lite transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
    endtask : bus

    // hang guard
    initial begin
        #400000;
        miscompares++;
        conclude();
    end

    initial begin
        int b, p, c, l, s;
        // a real falling edge at time zero, so the flops reset before any clock
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, one unmapped word
        foreach (RA[i]) begin
            bus(1'b0, RA[i], 32'h0);
            chk(rd, RV[i]);
        end
        chk(kbd_lock, 1'b0);
        chk(shift_figs, 1'b0);
        // bell twice in figures, then none in letters
        b = n_bell;
        p = n_prt;
        sel.send('{`PFD_CODE_FIGS, `PFD_CODE_SIGNAL, `PFD_CODE_SIGNAL});
        repeat (3) @(posedge hclk);
        chk(n_bell - b, 2);
        chk(n_prt - p, 0);
        chk(shift_figs, 1'b1);
        sel.send('{`PFD_CODE_LTRS, `PFD_CODE_SIGNAL});
        repeat (3) @(posedge hclk);
        chk(n_bell - b, 2);
        chk(n_prt - p, 1);
        // space unshifts, still spaces, prints nothing
        s = n_spc;
        p = n_prt;
        sel.send('{`PFD_CODE_FIGS, `PFD_CODE_SPACE});
        repeat (3) @(posedge hclk);
        chk(shift_figs, 1'b0);
        chk(n_spc - s, 1);
        chk(n_prt - p, 0);
        bus(1'b1, `PFD_OFS_CTRL, 32'h0);
        sel.send('{`PFD_CODE_FIGS, `PFD_CODE_SPACE});
        repeat (3) @(posedge hclk);
        chk(shift_figs, 1'b1);
        chk(n_spc - s, 2);
        bus(1'b1, `PFD_OFS_CTRL, 32'h1);
        sel.send('{`PFD_CODE_LTRS});
        repeat (3) @(posedge hclk);
        // blank, other, then blank pair
        sel.send('{`PFD_CODE_BLANK});
        repeat (3) @(posedge hclk);
        chk(kbd_lock, 1'b0);
        bus(1'b0, `PFD_OFS_STATUS, 32'h0);
        chk(rd, 32'h2);
        sel.send('{5'h03});
        repeat (3) @(posedge hclk);
        bus(1'b0, `PFD_OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        sel.send('{`PFD_CODE_BLANK, `PFD_CODE_BLANK});
        repeat (3) @(posedge hclk);
        chk(kbd_lock, 1'b1);
        bus(1'b0, `PFD_OFS_STATUS, 32'h0);
        chk(rd, 32'h4);
        bus(1'b1, `PFD_OFS_CTRL, 32'h3);
        repeat (2) @(posedge hclk);
        chk(kbd_lock, 1'b0);
        // short line: return first, then fill up to the margin
        c = n_cr;
        l = n_lf;
        sel.send('{`PFD_CODE_CR});
        repeat (3) @(posedge hclk);
        bus(1'b1, `PFD_OFS_LINE_LEN, 32'h5);
        sel.send('{5'h03, 5'h03, 5'h03});
        repeat (3) @(posedge hclk);
        chk(n_cr - c, 1);
        chk(n_lf - l, 0);
        sel.send('{5'h03});
        repeat (4) @(posedge hclk);
        chk(n_cr - c, 2);
        chk(n_lf - l, 1);
        bus(1'b0, `PFD_OFS_COLUMN, 32'h0);
        chk(rd, 32'h0);
        // end-of-line contact path
        sel.eol_hit();
        repeat (4) @(posedge hclk);
        chk(n_cr - c, 3);
        chk(n_lf - l, 2);
        // mid-run reset in figures shift restores letters and the default line length
        sel.send('{`PFD_CODE_FIGS});
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(shift_figs, 1'b0);
        bus(1'b0, `PFD_OFS_LINE_LEN, 32'h0);
        chk(rd, 32'h48);
        conclude();
    end
endmodule : pfd_printer_function_decoder_tb_top
